// [design/gpio_edge_interrupt_port.sv]
// Purpose: Edge interrupt control for an eight-pin port and the data,
//    input, direction, drive and pull registers of a two-pin port.
// Assumes: Pin inputs change relative to clk_sys; they are resynchronised.
// Notes: Read data appear one cycle after the read strobe and only then.
//
// How it works
// RULE_01 - Polarity clear: falling edge sets flag.
// RULE_02 - Polarity set: rising edge sets flag.
// RULE_03 - Polarity also picks pull-up or pull-down.
// RULE_04 - Enable bit gates each flag's request.
// RULE_05 - Active edge sets the pin's flag.
// RULE_06 - Writing one clears a flag; zero keeps.
// RULE_07 - Request while any enabled flag set.
// RULE_08 - Data read: latch if output, else pin.
// RULE_09 - Input register shows pins, ignores writes.
// RULE_10 - Direction bit: zero input, one output.
// RULE_11 - Reads settle two cycles after direction change.
// RULE_12 - Low-drive bit matters only for outputs.
// RULE_13 - Pull enable acts on inputs only.
// RULE_14 - First port pulls enabled per bit, off.
// RULE_15 - Two-stage sync, edge compare, set wins.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module gpio_edge_interrupt_port (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [gpio_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [gpio_pkg::DATA_W-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [gpio_pkg::DATA_W-1:0] bus_rdata,
   output logic irq,
   input wire logic [gpio_pkg::P1_W-1:0] p1_pin_in,
   input wire logic [gpio_pkg::P1_W-1:0] p1_pin_is_output,
   output logic [gpio_pkg::P1_W-1:0] p1_pull_up,
   output logic [gpio_pkg::P1_W-1:0] p1_pull_down,
   input wire logic [gpio_pkg::P2_W-1:0] p2_pin_in,
   output logic [gpio_pkg::P2_W-1:0] p2_pin_out,
   output logic [gpio_pkg::P2_W-1:0] p2_pin_oe,
   output logic [gpio_pkg::P2_W-1:0] p2_low_drive,
   output logic [gpio_pkg::P2_W-1:0] p2_pull_en
);
   import gpio_pkg::*;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic [DATA_W-1:0] p2_word(input logic [1:0] v);
      p2_word = {v, 6'h00};
   endfunction

   logic [P1_W-1:0] first_port_polarity_bits_reg;
   logic [P1_W-1:0] first_port_irq_enable_bits_reg;
   logic [P1_W-1:0] first_port_irq_flag_bits_reg;
   logic [P1_W-1:0] first_port_irq_flag_bits_next;
   logic [P1_W-1:0] first_port_pull_enable_bits_reg;
   logic [P2_W-1:0] second_port_data_bits_reg;
   logic [P2_W-1:0] second_port_direction_bits_reg;
   logic [P2_W-1:0] second_port_low_drive_bits_reg;
   logic [P2_W-1:0] second_port_pull_enable_bits_reg;
   logic [P1_W-1:0] p1_meta_reg;
   logic [P1_W-1:0] p1_sync_reg;
   logic [P1_W-1:0] p1_prev_reg;
   logic [2:0] sync_fill_reg;
   logic [P2_W-1:0] p2_meta_reg;
   logic [P2_W-1:0] second_port_pin_levels;
   logic [P1_W-1:0] fall_ev;
   logic [P1_W-1:0] rise_ev;
   logic [P1_W-1:0] set_ev;
   logic [P1_W-1:0] clr_mask;
   logic [P2_W-1:0] p2_data_view;
   logic [DATA_W-1:0] rd_next;
   logic irq_reg;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // RULE_15 two-stage sync
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         p1_meta_reg <= 8'h00;
         p1_sync_reg <= 8'h00;
         p1_prev_reg <= 8'h00;
         sync_fill_reg <= 3'h0;
      end else begin
         p1_meta_reg <= p1_pin_in;
         p1_sync_reg <= p1_meta_reg;
         p1_prev_reg <= p1_sync_reg;
         sync_fill_reg <= {sync_fill_reg[1:0], 1'b1};
      end
   end

   // RULE_11 sync settle delay
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         p2_meta_reg <= 2'h0;
         second_port_pin_levels <= 2'h0;
      end else begin
         p2_meta_reg <= p2_pin_in;
         second_port_pin_levels <= p2_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // Edge detection and flags
   // ----------------------------------------------------------------
   // Until the pipeline has refilled after reset the older sample holds
   // the reset value, not the pin, so a false edge would follow reset.
   // RULE_15 compare consecutive samples
   assign fall_ev = (p1_prev_reg & ~p1_sync_reg) & {P1_W{sync_fill_reg[2]}};
   assign rise_ev = (~p1_prev_reg & p1_sync_reg) & {P1_W{sync_fill_reg[2]}};
   // RULE_01 falling edge when clear
   // RULE_02 rising edge when set
   assign set_ev = (fall_ev & ~first_port_polarity_bits_reg) |
                   (rise_ev & first_port_polarity_bits_reg);
   // RULE_06 write one clears
   assign clr_mask = (bus_wr && hit(bus_addr, OFF_IRQ_FLAGS)) ?
                     bus_wdata : 8'h00;

   // Set is applied after the clear so an edge in the clearing cycle
   // survives; software never loses an event this way.
   // RULE_05 edge sets flag
   // RULE_15 set beats clear
   always_comb begin
      first_port_irq_flag_bits_next =
         (first_port_irq_flag_bits_reg & ~clr_mask) | set_ev;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         first_port_irq_flag_bits_reg <= RST_IRQ_FLAGS;
      end else begin
         first_port_irq_flag_bits_reg <= first_port_irq_flag_bits_next;
      end
   end

   // RULE_04 enable masks flag
   // RULE_07 any enabled flag requests
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(first_port_irq_flag_bits_reg &
                      first_port_irq_enable_bits_reg);
      end
   end
   assign irq = irq_reg;

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         first_port_polarity_bits_reg <= RST_POLARITY;
         first_port_irq_enable_bits_reg <= RST_IRQ_EN;
         first_port_pull_enable_bits_reg <= RST_P1_PULL_EN;
      end else if (bus_wr) begin
         if (hit(bus_addr, OFF_POLARITY)) begin
            first_port_polarity_bits_reg <= bus_wdata;
         end
         if (hit(bus_addr, OFF_IRQ_EN)) begin
            first_port_irq_enable_bits_reg <= bus_wdata;
         end
         // RULE_14 first port pull enable
         if (hit(bus_addr, OFF_P1_PULL_EN)) begin
            first_port_pull_enable_bits_reg <= bus_wdata;
         end
      end
   end

   // Writes to the pin input offset match no branch and are dropped.
   // RULE_09 writes ignored
   // RULE_10 direction register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         second_port_data_bits_reg <= RST_P2_DATA;
         second_port_direction_bits_reg <= RST_P2_DIR;
         second_port_low_drive_bits_reg <= RST_P2_LOW_DRV;
         second_port_pull_enable_bits_reg <= RST_P2_PULL_EN;
      end else if (bus_wr) begin
         if (hit(bus_addr, OFF_P2_DATA)) begin
            second_port_data_bits_reg <= bus_wdata[P2_MSB:P2_LSB];
         end
         if (hit(bus_addr, OFF_P2_DIR)) begin
            second_port_direction_bits_reg <= bus_wdata[P2_MSB:P2_LSB];
         end
         if (hit(bus_addr, OFF_P2_LOW_DRV)) begin
            second_port_low_drive_bits_reg <= bus_wdata[P2_MSB:P2_LSB];
         end
         if (hit(bus_addr, OFF_P2_PULL_EN)) begin
            second_port_pull_enable_bits_reg <= bus_wdata[P2_MSB:P2_LSB];
         end
      end
   end

   // ----------------------------------------------------------------
   // Pad controls
   // ----------------------------------------------------------------
   // RULE_03 polarity selects pull
   // RULE_14 pull only on inputs
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         p1_pull_up <= 8'h00;
         p1_pull_down <= 8'h00;
      end else begin
         p1_pull_up <= first_port_pull_enable_bits_reg &
                       ~first_port_polarity_bits_reg & ~p1_pin_is_output;
         p1_pull_down <= first_port_pull_enable_bits_reg &
                         first_port_polarity_bits_reg & ~p1_pin_is_output;
      end
   end

   // All pad controls share one register stage so that enable, drive
   // strength and pull never disagree for a cycle.
   // RULE_10 one drives pin
   // RULE_12 low drive on outputs
   // RULE_13 pull on inputs only
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         p2_pin_out <= 2'h0;
         p2_pin_oe <= 2'h0;
         p2_low_drive <= 2'h0;
         p2_pull_en <= 2'h0;
      end else begin
         p2_pin_out <= second_port_data_bits_reg;
         p2_pin_oe <= second_port_direction_bits_reg;
         p2_low_drive <= second_port_low_drive_bits_reg &
                         second_port_direction_bits_reg;
         p2_pull_en <= second_port_pull_enable_bits_reg &
                       ~second_port_direction_bits_reg;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // RULE_08 output latch or pin
   assign p2_data_view =
      (second_port_data_bits_reg & second_port_direction_bits_reg) |
      (second_port_pin_levels & ~second_port_direction_bits_reg);

   always_comb begin
      rd_next = READ_NONE;
      if (bus_rd) begin
         unique case (bus_addr)
            OFF_P1_PULL_EN: rd_next = first_port_pull_enable_bits_reg;
            OFF_POLARITY: rd_next = first_port_polarity_bits_reg;
            OFF_IRQ_EN: rd_next = first_port_irq_enable_bits_reg;
            OFF_IRQ_FLAGS: rd_next = first_port_irq_flag_bits_reg;
            OFF_P2_DATA: rd_next = p2_word(p2_data_view);
            // RULE_09 always pin levels
            OFF_P2_PIN_IN: rd_next = p2_word(second_port_pin_levels);
            OFF_P2_DIR: rd_next = p2_word(second_port_direction_bits_reg);
            OFF_P2_LOW_DRV: rd_next = p2_word(second_port_low_drive_bits_reg);
            OFF_P2_PULL_EN:
               rd_next = p2_word(second_port_pull_enable_bits_reg);
            default: rd_next = READ_NONE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         bus_rdata <= READ_NONE;
      end else begin
         bus_rdata <= rd_next;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   a_fall_sets_flag: assert property ( // RULE_01
      |(fall_ev & ~first_port_polarity_bits_reg) |=>
      (first_port_irq_flag_bits_reg & $past(fall_ev) &
       ~$past(first_port_polarity_bits_reg)) ==
      ($past(fall_ev) & ~$past(first_port_polarity_bits_reg)))
      else $error("falling edge did not set its flag");

   a_rise_sets_flag: assert property ( // RULE_02
      |(rise_ev & first_port_polarity_bits_reg) |=>
      (first_port_irq_flag_bits_reg & $past(rise_ev) &
       $past(first_port_polarity_bits_reg)) ==
      ($past(rise_ev) & $past(first_port_polarity_bits_reg)))
      else $error("rising edge did not set its flag");

   a_pull_exclusive: assert property ( // RULE_03
      (p1_pull_up & p1_pull_down) == 8'h00)
      else $error("pull-up and pull-down both on");

   a_irq_follows: assert property ( // RULE_07
      irq == |($past(first_port_irq_flag_bits_reg) &
               $past(first_port_irq_enable_bits_reg)))
      else $error("interrupt does not follow enabled flags");

   a_flag_w1c: assert property ( // RULE_06
      bus_wr && hit(bus_addr, OFF_IRQ_FLAGS) && set_ev == 8'h00 |=>
      first_port_irq_flag_bits_reg ==
      ($past(first_port_irq_flag_bits_reg) & ~$past(bus_wdata)))
      else $error("flag write-one-to-clear wrong");

   a_data_read: assert property ( // RULE_08
      bus_rd && hit(bus_addr, OFF_P2_DATA) |=>
      bus_rdata == p2_word($past(p2_data_view)))
      else $error("second port data read wrong");

   a_pin_read: assert property ( // RULE_09
      bus_rd && hit(bus_addr, OFF_P2_PIN_IN) ##1 1'b1 |->
      bus_rdata[P2_MSB:P2_LSB] == $past(p2_meta_reg, 2))
      else $error("pin input read wrong");

   a_low_drive_out: assert property ( // RULE_12
      (p2_low_drive & ~p2_pin_oe) == 2'h0)
      else $error("low drive on an input pin");

   a_pull_inputs: assert property ( // RULE_13
      (p2_pull_en & p2_pin_oe) == 2'h0)
      else $error("pull enabled on a driven pin");

   a_sync_edge: assert property ( // RULE_15
      sync_fill_reg[2] && $fell(p1_pin_in[0]) |-> ##2 fall_ev[0])
      else $error("edge not seen two cycles after pin");

   a_flag_only_edge: assert property ( // RULE_05
      (first_port_irq_flag_bits_reg &
       ~$past(first_port_irq_flag_bits_reg) & ~$past(set_ev)) == 8'h00)
      else $error("flag set without an active edge");

   a_set_beats_clear: assert property ( // RULE_15
      |(set_ev & clr_mask) |=>
      (first_port_irq_flag_bits_reg & $past(set_ev)) == $past(set_ev))
      else $error("clear overrode a simultaneous edge");

   a_irq_masked: assert property ( // RULE_04
      first_port_irq_enable_bits_reg == 8'h00 |=> !irq)
      else $error("interrupt raised while all pins masked");

   a_pull_needs_enable: assert property ( // RULE_14
      ((p1_pull_up | p1_pull_down) &
       ~$past(first_port_pull_enable_bits_reg)) == 8'h00)
      else $error("pull device on without its enable");

   a_oe_follows_dir: assert property ( // RULE_10
      p2_pin_oe == $past(second_port_direction_bits_reg) &&
      p2_pin_out == $past(second_port_data_bits_reg))
      else $error("pad drive does not follow direction and data");

   a_low_drive_follows: assert property ( // RULE_12
      p2_low_drive == ($past(second_port_low_drive_bits_reg) &
                       $past(second_port_direction_bits_reg)))
      else $error("low drive does not follow its register");

   a_read_idle: assert property ( // RULE_08
      !bus_rd |=> bus_rdata == READ_NONE)
      else $error("read data present without a read");

   c_flag_set: cover property (|set_ev ##1 |first_port_irq_flag_bits_reg);
   c_irq_rise: cover property ($rose(irq));
   c_set_wins: cover property (|(set_ev & clr_mask));
   c_clear_flag: cover property (bus_wr && hit(bus_addr, OFF_IRQ_FLAGS)
      && |(bus_wdata & first_port_irq_flag_bits_reg));
   c_read_output: cover property (bus_rd && hit(bus_addr, OFF_P2_DATA)
      && |second_port_direction_bits_reg);
endmodule

// [design/gpio_pkg.sv]
// Purpose: Shared constants for the edge interrupt and second port block.
// Assumes: Eight-bit register bus with byte offsets as listed here.
// Notes: Second port implements pins 7 and 6 only.
package gpio_pkg;
   // ----------------------------------------------------------------
   // Bus widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int P1_W = 8;
   localparam int P2_W = 2;
   localparam int P2_LSB = 6;
   localparam int P2_MSB = 7;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_P1_PULL_EN = 8'h1c;
   localparam logic [7:0] OFF_POLARITY = 8'h1d;
   localparam logic [7:0] OFF_IRQ_EN = 8'h1e;
   localparam logic [7:0] OFF_IRQ_FLAGS = 8'h1f;
   localparam logic [7:0] OFF_P2_DATA = 8'h28;
   localparam logic [7:0] OFF_P2_PIN_IN = 8'h29;
   localparam logic [7:0] OFF_P2_DIR = 8'h2a;
   localparam logic [7:0] OFF_P2_LOW_DRV = 8'h2b;
   localparam logic [7:0] OFF_P2_PULL_EN = 8'h2c;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_P1_PULL_EN = 8'h00;
   localparam logic [7:0] RST_POLARITY = 8'h00;
   localparam logic [7:0] RST_IRQ_EN = 8'h00;
   localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
   localparam logic [1:0] RST_P2_DATA = 2'h0;
   localparam logic [1:0] RST_P2_DIR = 2'h0;
   localparam logic [1:0] RST_P2_LOW_DRV = 2'h0;
   localparam logic [1:0] RST_P2_PULL_EN = 2'h0;
   localparam logic [7:0] READ_NONE = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SETTLE_BUS_CYCLES = 2;
endpackage

// [testbench/board_pins.sv]
// Purpose: Board model for the pins of both ports.
// Assumes: The pad pull on the second port pulls up.
// Notes: An undriven, unpulled pin toggles so it never looks stable.
`timescale 1ns/1ps
module board_pins (
   input wire logic clk_sys,
   input wire logic [7:0] p1_level,
   input wire logic [1:0] p2_force,
   input wire logic [1:0] p2_force_en,
   input wire logic [1:0] p2_pin_out,
   input wire logic [1:0] p2_pin_oe,
   input wire logic [1:0] p2_pull_en,
   output logic [7:0] p1_pin_in,
   output logic [1:0] p2_pin_in
);
   logic tog_reg = 1'b0;
   always_ff @(posedge clk_sys) begin
      tog_reg <= ~tog_reg;
   end
   assign p1_pin_in = p1_level;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (p2_pin_oe[i]) begin
            p2_pin_in[i] = p2_pin_out[i];
         end else if (p2_force_en[i]) begin
            p2_pin_in[i] = p2_force[i];
         end else if (p2_pull_en[i]) begin
            p2_pin_in[i] = 1'b1;
         end else begin
            p2_pin_in[i] = tog_reg;
         end
      end
   end
endmodule

// [testbench/gpio_edge_interrupt_port_tb_top.sv]
// Purpose: Self-checking bench for the edge interrupt and second port.
// Assumes: Pin changes reach the flags within five clock cycles.
// Notes: Only mismatches and the verdict are printed.
`timescale 1ns/1ps
module gpio_edge_interrupt_port_tb_top;
   import gpio_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] bus_addr = 8'h00;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_rdata;
   logic irq;
   logic [7:0] p1_level = 8'hff;
   logic [7:0] p1_is_out = 8'h00;
   logic [7:0] p1_pin_in, pull_up, pull_down;
   logic [1:0] p2_pin_in, p2_out, p2_oe, p2_low, p2_pull;
   logic [1:0] p2_force = 2'h2;
   logic [1:0] p2_force_en = 2'h3;
   int fail_count = 0;
   int check_count = 0;

   gpio_edge_interrupt_port gpio_edge_interrupt_port_i (
      .clk_sys(clk_sys), .arst_n(arst_n), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .irq(irq), .p1_pin_in(p1_pin_in),
      .p1_pin_is_output(p1_is_out), .p1_pull_up(pull_up),
      .p1_pull_down(pull_down), .p2_pin_in(p2_pin_in),
      .p2_pin_out(p2_out), .p2_pin_oe(p2_oe), .p2_low_drive(p2_low),
      .p2_pull_en(p2_pull));
   board_pins board_pins_i (
      .clk_sys(clk_sys), .p1_level(p1_level), .p2_force(p2_force),
      .p2_force_en(p2_force_en), .p2_pin_out(p2_out), .p2_pin_oe(p2_oe),
      .p2_pull_en(p2_pull), .p1_pin_in(p1_pin_in), .p2_pin_in(p2_pin_in));

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] e, g);
      check_count++;
      if (e !== g) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_sys);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge clk_sys);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), e, bus_rdata);
   endtask
   task automatic test_done();
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic reset_values();
      rd(OFF_P1_PULL_EN, 8'h00);
      rd(OFF_POLARITY, 8'h00);
      rd(OFF_IRQ_EN, 8'h00);
      rd(OFF_IRQ_FLAGS, 8'h00);
      rd(OFF_P2_DIR, 8'h00);
      chk("pull_up", 8'h00, pull_up);
      chk("irq", 8'h00, {7'h00, irq});
   endtask
   task automatic falling_edges();
      wr(OFF_IRQ_EN, 8'h01);
      @(posedge clk_sys) p1_level <= 8'h00;
      wt(6);
      rd(OFF_IRQ_FLAGS, 8'hff);
      chk("irq", 8'h01, {7'h00, irq});
      @(posedge clk_sys) p1_level <= 8'hff;
      wt(6);
      rd(OFF_IRQ_FLAGS, 8'hff);
      wr(OFF_IRQ_FLAGS, 8'h00);
      rd(OFF_IRQ_FLAGS, 8'hff);
      wr(OFF_IRQ_FLAGS, 8'hfe);
      rd(OFF_IRQ_FLAGS, 8'h01);
      wr(OFF_IRQ_EN, 8'h00);
      wt(2);
      chk("irq", 8'h00, {7'h00, irq});
      wr(OFF_IRQ_EN, 8'h01);
      wt(2);
      chk("irq", 8'h01, {7'h00, irq});
      wr(OFF_IRQ_FLAGS, 8'h01);
      wt(2);
      chk("irq", 8'h00, {7'h00, irq});
   endtask
   task automatic rising_edges();
      wr(OFF_POLARITY, 8'hff);
      wr(OFF_IRQ_EN, 8'hff);
      @(posedge clk_sys) p1_level <= 8'h00;
      wt(6);
      rd(OFF_IRQ_FLAGS, 8'h00);
      @(posedge clk_sys) p1_level <= 8'hff;
      wt(6);
      rd(OFF_IRQ_FLAGS, 8'hff);
      chk("irq", 8'h01, {7'h00, irq});
      wr(OFF_IRQ_FLAGS, 8'hff);
      rd(OFF_IRQ_FLAGS, 8'h00);
   endtask
   task automatic first_pulls();
      wr(OFF_P1_PULL_EN, 8'hff);
      wr(OFF_POLARITY, 8'h0f);
      @(posedge clk_sys) p1_is_out <= 8'h03;
      wt(3);
      chk("pull_up", 8'hf0, pull_up);
      chk("pull_down", 8'h0c, pull_down);
      rd(OFF_P1_PULL_EN, 8'hff);
   endtask
   task automatic set_wins();
      @(posedge clk_sys) p1_level <= 8'h7f;
      @(posedge clk_sys);
      wr(OFF_IRQ_FLAGS, 8'h80);
      rd(OFF_IRQ_FLAGS, 8'h80);
      wr(OFF_IRQ_FLAGS, 8'h80);
      rd(OFF_IRQ_FLAGS, 8'h00);
      @(posedge clk_sys) p1_level <= 8'hff;
   endtask
   task automatic mid_reset();
      @(posedge clk_sys) arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      wr(OFF_POLARITY, 8'hff);
      wt(4);
      rd(OFF_IRQ_FLAGS, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      chk("pull_up", 8'h00, pull_up);
      chk("pull_down", 8'h00, pull_down);
      rd(OFF_P1_PULL_EN, 8'h00);
   endtask
   task automatic second_port();
      rd(OFF_P2_PIN_IN, 8'h80);
      wr(OFF_P2_DATA, 8'h40);
      rd(OFF_P2_DATA, 8'h80);
      chk("pin_out", 8'h01, {6'h00, p2_out});
      wr(OFF_P2_DIR, 8'hc0);
      wt(3);
      rd(OFF_P2_DATA, 8'h40);
      rd(OFF_P2_PIN_IN, 8'h40);
      wr(OFF_P2_PIN_IN, 8'hff);
      rd(OFF_P2_PIN_IN, 8'h40);
      chk("oe", 8'h03, {6'h00, p2_oe});
      wr(OFF_P2_LOW_DRV, 8'hc0);
      wr(OFF_P2_PULL_EN, 8'hc0);
      wt(2);
      chk("low", 8'h03, {6'h00, p2_low});
      chk("pull", 8'h00, {6'h00, p2_pull});
      wr(OFF_P2_DIR, 8'h40);
      wt(SETTLE_BUS_CYCLES);
      chk("low", 8'h01, {6'h00, p2_low});
      chk("pull", 8'h02, {6'h00, p2_pull});
      rd(OFF_P2_DATA, 8'hc0);
      rd(OFF_P2_DIR, 8'h40);
      rd(8'h2d, 8'h00);
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'b1;
      wt(2);
      reset_values();
      falling_edges();
      rising_edges();
      first_pulls();
      set_wins();
      mid_reset();
      second_port();
      test_done();
   end

   initial begin
      #200000;
      fail_count++;
      test_done();
   end
endmodule
